//--- hdl/camera_gpio_pkg.sv
// Package with register map, field layout and timing for the camera lines
`default_nettype none
package camera_gpio_pkg;
    localparam int          NUM_LINES      = 4;
    localparam int          SPAN_W         = 16;
    localparam int          CLK_MHZ        = 40;
    localparam int          US_TICK_CYCLES = CLK_MHZ;
    // Register byte offsets
    localparam logic [11:0] OFS_LINE_SEL   = 12'h000;
    localparam logic [11:0] OFS_LINE_CFG   = 12'h004;
    localparam logic [11:0] OFS_FILT_SEL   = 12'h008;
    localparam logic [11:0] OFS_FILT_SPAN  = 12'h00C;
    localparam logic [11:0] OFS_LEVEL      = 12'h010;
    localparam logic [11:0] OFS_LEVEL_VEC  = 12'h014;
    localparam logic [11:0] OFS_SW_SEL     = 12'h018;
    localparam logic [11:0] OFS_SW_LEVEL   = 12'h01C;
    localparam logic [11:0] OFS_SW_VEC     = 12'h020;
    localparam logic [11:0] OFS_KIND       = 12'h024;
    // Line configuration field positions
    localparam int          CFG_DIR_BIT    = 0;
    localparam int          CFG_INV_BIT    = 1;
    localparam int          CFG_SRC_LSB    = 4;
    localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
    localparam logic [1:0]  KIND_RESET     = 2'h2;

    typedef enum logic [1:0] {
        KIND_TRISTATE, KIND_OPTO, KIND_OPEN_DRAIN
    } pin_circuit_kind_t;

    typedef enum logic [3:0] {
        SRC_LINE0, SRC_LINE1, SRC_LINE2, SRC_LINE3,
        SRC_USER0, SRC_USER1, SRC_USER2, SRC_USER3,
        SRC_COUNTER0, SRC_COUNTER1, SRC_LOGIC0, SRC_LOGIC1,
        SRC_EXPOSURE, SRC_TRIG_READY, SRC_ZERO_A, SRC_ZERO_B
    } output_source_select_t;

    typedef struct packed {
        output_source_select_t src;
        logic                  invert;
        logic                  is_output;
    } line_cfg_t;

    typedef struct packed {
        logic [1:0] counter_active;
        logic [1:0] logic_block;
        logic       exposure_active;
        logic       trigger_ready;
    } cam_signals_t;
endpackage : camera_gpio_pkg
`default_nettype wire

//--- hdl/camera_gpio_lines.sv
// Four-line camera GPIO block with filters, source mux and APB registers
`default_nettype none
module camera_gpio_lines
    import camera_gpio_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire cam_signals_t         cam_in,
    input  wire logic [NUM_LINES-1:0] pin_in,
    output logic      [NUM_LINES-1:0] pin_out,
    output logic      [NUM_LINES-1:0] pin_oe,
    output logic      [NUM_LINES-1:0] line_level
);
    // Circuit kind per line is fixed by the board; all lines here are open drain
    localparam pin_circuit_kind_t LINE_KIND = pin_circuit_kind_t'(KIND_RESET);

    line_cfg_t              cfg_reg [NUM_LINES];
    logic [SPAN_W-1:0]      glitch_us_reg [NUM_LINES];
    logic [SPAN_W-1:0]      bounce_us_reg [NUM_LINES];
    logic [1:0]             line_sel_reg;
    logic                   filt_kind_reg;
    logic [1:0]             sw_sel_reg;
    logic [NUM_LINES-1:0]   sw_vec_reg;
    logic [NUM_LINES-1:0]   sync1_reg;
    logic [NUM_LINES-1:0]   sync2_reg;
    logic [NUM_LINES-1:0]   glitch_out_reg;
    logic [NUM_LINES-1:0]   bounce_out_reg;
    logic [5:0]             us_cnt_reg;
    logic                   us_tick;
    logic [NUM_LINES-1:0]   drive_level;
    logic [NUM_LINES-1:0]   status;
    logic                   wr_en;
    logic                   rd_en;
    logic [31:0]            rd_next;
    logic                   map_hit;

    // Source mux shared by every line
    function automatic logic pick_source(
        input output_source_select_t src,
        input logic [NUM_LINES-1:0]  lines,
        input logic [NUM_LINES-1:0]  user,
        input cam_signals_t          cam
    );
        logic v;
        v = 1'b0;
        unique case (src)
            SRC_LINE0, SRC_LINE1, SRC_LINE2, SRC_LINE3:
                v = lines[src[1:0]];
            SRC_USER0, SRC_USER1, SRC_USER2, SRC_USER3:
                v = user[src[1:0]];
            SRC_COUNTER0:   v = cam.counter_active[0];
            SRC_COUNTER1:   v = cam.counter_active[1];
            SRC_LOGIC0:     v = cam.logic_block[0];
            SRC_LOGIC1:     v = cam.logic_block[1];
            SRC_EXPOSURE:   v = cam.exposure_active;
            SRC_TRIG_READY: v = cam.trigger_ready;
            SRC_ZERO_A, SRC_ZERO_B: v = 1'b0;
        endcase
        return v;
    endfunction : pick_source

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // Microsecond tick; debounce hold-offs count these ticks
    // microsecond time base
    assign us_tick = (us_cnt_reg == 6'(US_TICK_CYCLES - 1));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            us_cnt_reg <= 6'h00;
        end else if (us_tick) begin
            us_cnt_reg <= 6'h00;
        end else begin
            us_cnt_reg <= us_cnt_reg + 6'h01;
        end
    end

    // Two-flop synchroniser on the raw pins
    // input synchroniser
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Per-line filter pair; width resolution is one microsecond tick
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            logic [SPAN_W-1:0] gcnt_reg;
            logic [5:0]        gsub_reg;
            logic [SPAN_W:0]   bcnt_reg;
            logic              inv_in;
            assign inv_in = sync2_reg[gi] ^ cfg_reg[gi].invert;

            // deglitch waits for the level to persist
            // Own cycle count per line, so the full width always elapses
            // whatever the phase of the shared microsecond tick
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    gcnt_reg           <= '0;
                    gsub_reg           <= 6'h00;
                    glitch_out_reg[gi] <= 1'b0;
                end else if (inv_in == glitch_out_reg[gi]) begin
                    gcnt_reg <= '0;
                    gsub_reg <= 6'h00;
                end else if (gcnt_reg >= glitch_us_reg[gi]) begin
                    glitch_out_reg[gi] <= inv_in;
                    gcnt_reg           <= '0;
                    gsub_reg           <= 6'h00;
                end else if (gsub_reg == 6'(US_TICK_CYCLES - 1)) begin
                    gcnt_reg <= gcnt_reg + 1'b1;
                    gsub_reg <= 6'h00;
                end else begin
                    gsub_reg <= gsub_reg + 6'h01;
                end
            end

            // first edge passes, then a hold-off
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    bcnt_reg          <= '0;
                    bounce_out_reg[gi] <= 1'b0;
                end else if (bcnt_reg != '0) begin
                    if (us_tick) begin
                        bcnt_reg <= bcnt_reg - 1'b1;
                    end
                end else if (glitch_out_reg[gi] != bounce_out_reg[gi]) begin
                    bounce_out_reg[gi] <= glitch_out_reg[gi];
                    // One extra tick: the shared tick may fall at once,
                    // so the hold-off is never shorter than the span
                    bcnt_reg <= (bounce_us_reg[gi] == '0) ? '0
                        : {1'b0, bounce_us_reg[gi]} + 1'b1;
                end
            end

            assign drive_level[gi] =
                pick_source(cfg_reg[gi].src, bounce_out_reg, sw_vec_reg, cam_in)
                ^ cfg_reg[gi].invert;
            assign status[gi] = cfg_reg[gi].is_output ? drive_level[gi]
                                                      : bounce_out_reg[gi];
        end
    endgenerate

    // Open-drain pins: pull low for a zero, release for a one
    // drive only as output
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out    <= '0;
            pin_oe     <= '0;
            line_level <= '0;
        end else begin
            pin_out    <= '0;
            line_level <= status;
            for (int i = 0; i < NUM_LINES; i++) begin
                pin_oe[i] <= cfg_reg[i].is_output && !drive_level[i];
            end
        end
    end

    // Selectors and per-line settings
    // per-line storage by index
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            line_sel_reg  <= '0;
            filt_kind_reg <= 1'b0;
            sw_sel_reg    <= '0;
            for (int i = 0; i < NUM_LINES; i++) begin
                cfg_reg[i]       <= line_cfg_t'(RESET_VALUE[5:0]);
                glitch_us_reg[i] <= '0;
                bounce_us_reg[i] <= '0;
            end
        end else if (wr_en) begin
            unique case (paddr)
                OFS_LINE_SEL: line_sel_reg  <= pwdata[1:0];
                OFS_FILT_SEL: filt_kind_reg <= pwdata[0];
                OFS_SW_SEL:   sw_sel_reg    <= pwdata[1:0];
                OFS_LINE_CFG: begin
                    cfg_reg[line_sel_reg].is_output <= pwdata[CFG_DIR_BIT];
                    cfg_reg[line_sel_reg].invert    <= pwdata[CFG_INV_BIT];
                    cfg_reg[line_sel_reg].src <= output_source_select_t'(
                        pwdata[CFG_SRC_LSB +: 4]);
                end
                OFS_FILT_SPAN: begin
                    if (filt_kind_reg) begin
                        bounce_us_reg[line_sel_reg] <= pwdata[SPAN_W-1:0];
                    end else begin
                        glitch_us_reg[line_sel_reg] <= pwdata[SPAN_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // User output bits: single-bit level write or whole vector
    // selected bit level write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_vec_reg <= '0;
        end else if (wr_en && paddr == OFS_SW_LEVEL) begin
            sw_vec_reg[sw_sel_reg] <= pwdata[0];
        end else if (wr_en && paddr == OFS_SW_VEC) begin
            sw_vec_reg <= pwdata[NUM_LINES-1:0];
        end
    end

    // Read decode
    always_comb begin
        rd_next = '0;
        map_hit = 1'b1;
        unique case (paddr)
            OFS_LINE_SEL:  rd_next[1:0] = line_sel_reg;
            OFS_LINE_CFG:  rd_next[7:0] = {cfg_reg[line_sel_reg].src,
                2'b00, cfg_reg[line_sel_reg].invert,
                cfg_reg[line_sel_reg].is_output};
            OFS_FILT_SEL:  rd_next[0] = filt_kind_reg;
            OFS_FILT_SPAN: rd_next[SPAN_W-1:0] = filt_kind_reg
                ? bounce_us_reg[line_sel_reg] : glitch_us_reg[line_sel_reg];
            OFS_LEVEL:     rd_next[0] = status[line_sel_reg];
            // all levels, line n at bit n
            OFS_LEVEL_VEC: rd_next[NUM_LINES-1:0] = status;
            OFS_SW_SEL:    rd_next[1:0] = sw_sel_reg;
            OFS_SW_LEVEL:  rd_next[0] = sw_vec_reg[sw_sel_reg];
            OFS_SW_VEC:    rd_next[NUM_LINES-1:0] = sw_vec_reg;
            OFS_KIND:      rd_next[1:0] = LINE_KIND;
            default:       map_hit = 1'b0;
        endcase
    end

    // APB answer: one wait state, so pready rises in the second access cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !map_hit;
            prdata  <= (rd_en && !pready) ? rd_next : 32'h0000_0000;
        end
    end

    // Checks
    sequence s_out_low(i);
        cfg_reg[i].is_output && !drive_level[i];
    endsequence

    a_pin_drive_out: assert property (@(posedge mclk) disable iff (!rst_n)
        s_out_low(0) |=> pin_oe[0])
        else $error("line 0 output low not driven");
    a_input_never_oe: assert property (@(posedge mclk) disable iff (!rst_n)
        !cfg_reg[1].is_output |=> !pin_oe[1])
        else $error("input line driven");
    a_od_never_high: assert property (@(posedge mclk) disable iff (!rst_n)
        pin_oe != '0 |-> pin_out == '0)
        else $error("open drain drove high");
    a_level_vector: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> line_level == $past(status))
        else $error("level vector stale");
    logic inv_cmp2;
    assign inv_cmp2 = g_line[2].inv_in != glitch_out_reg[2];
    a_glitch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(glitch_out_reg[2]) |-> $past(inv_cmp2))
        else $error("deglitch changed without persisted input");
    a_glitch_span: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(glitch_out_reg[2])
        |-> $past(g_line[2].gcnt_reg) >= $past(glitch_us_reg[2]))
        else $error("deglitch accepted before full width");
    a_bounce_lock: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(g_line[0].bcnt_reg) != '0 |-> $stable(bounce_out_reg[0]))
        else $error("debounce changed during hold-off");
    a_bounce_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        g_line[0].bcnt_reg == '0 && glitch_out_reg[0] != bounce_out_reg[0]
        |=> bounce_out_reg[0] == $past(glitch_out_reg[0]))
        else $error("debounce missed deglitch edge");
    a_us_tick: assert property (@(posedge mclk) disable iff (!rst_n)
        us_tick |=> !us_tick [*3])
        else $error("microsecond tick too fast");
    a_sw_vec_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && paddr == OFS_SW_VEC |=> sw_vec_reg == $past(pwdata[3:0]))
        else $error("user vector write lost");
    a_apb_ready: assert property (@(posedge mclk) disable iff (!rst_n)
        psel && penable && !pready |=> pready)
        else $error("apb ready late");

    // Register side checks; all but a_trig_source and a_sync_chain look one cycle after the first access
    // cycle, where the registered answer stands
    a_slverr_unmapped: assert property (@(posedge mclk) disable iff (!rst_n)
        psel && penable && !pready && !map_hit |=> pslverr)
        else $error("unmapped access not refused");
    a_cfg_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && paddr == OFS_LINE_CFG
        |=> cfg_reg[line_sel_reg].is_output == $past(pwdata[0]))
        else $error("direction write lost");
    a_level_read: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && !pready && paddr == OFS_LEVEL
        |=> prdata[0] == $past(status[line_sel_reg]))
        else $error("line level read wrong");
    a_vec_read: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && !pready && paddr == OFS_LEVEL_VEC
        |=> prdata[3:0] == $past(status))
        else $error("level vector read wrong");
    a_span_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && paddr == OFS_FILT_SPAN && !filt_kind_reg
        |=> glitch_us_reg[line_sel_reg] == $past(pwdata[15:0]))
        else $error("deglitch span write lost");
    a_trig_source: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_reg[3].src == SRC_TRIG_READY |-> drive_level[3]
        == (cam_in.trigger_ready ^ cfg_reg[3].invert))
        else $error("trigger ready not routed");
    a_sw_bit_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && paddr == OFS_SW_LEVEL
        |=> sw_vec_reg[sw_sel_reg] == $past(pwdata[0]))
        else $error("user bit write lost");
    a_kind_read: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && !pready && paddr == OFS_KIND
        |=> prdata[1:0] == 2'(LINE_KIND))
        else $error("circuit kind read wrong");
    a_sync_chain: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> sync2_reg == $past(sync1_reg))
        else $error("synchroniser stage skipped");
endmodule : camera_gpio_lines
`default_nettype wire

//--- verification/wire_pullup_model.sv
// External wiring model: pull-up resistor plus an optional sink per line
`default_nettype none
module wire_pullup_model
    import camera_gpio_pkg::*;
(
    input  wire logic [NUM_LINES-1:0] pin_oe,
    input  wire logic [NUM_LINES-1:0] pin_out,
    input  wire logic [NUM_LINES-1:0] ext_low,
    output logic      [NUM_LINES-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up forms high
    // Either party may only sink; pin_out is ignored since a drain never
    // sources, so a high on it would hide a wrong enable
    always_comb begin
        pin_in = ~(pin_oe | ext_low);
    end
endmodule : wire_pullup_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the four camera lines over APB
`default_nettype none
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
    bad_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module testbench
    import camera_gpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [11:0] addr;
        logic        wr;
        logic [31:0] data;
        logic [31:0] exp;
        logic        err;
    } reg_row_t;
    logic                 mclk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    cam_signals_t         cam_in = '0;
    logic [NUM_LINES-1:0] pin_in;
    logic [NUM_LINES-1:0] pin_out;
    logic [NUM_LINES-1:0] pin_oe;
    logic [NUM_LINES-1:0] line_level;
    logic [NUM_LINES-1:0] ext_low = 4'h0;
    logic [31:0]          rd_v;
    logic                 er_v;
    logic                 ok;
    int                   bad_count = 0;
    int                   check_count = 0;
    reg_row_t rows[14] = '{
        '{OFS_KIND, 0, 0, 32'h2, 0},
        '{OFS_SW_VEC, 1, 32'h5, 0, 0},
        '{OFS_SW_VEC, 0, 0, 32'h5, 0},
        '{OFS_SW_SEL, 1, 32'h1, 0, 0},
        '{OFS_SW_LEVEL, 1, 32'h1, 0, 0},
        '{OFS_SW_VEC, 0, 0, 32'h7, 0},
        '{OFS_LINE_SEL, 1, 32'h2, 0, 0},
        '{OFS_LINE_CFG, 1, 32'h51, 0, 0},
        '{OFS_LINE_CFG, 0, 0, 32'h51, 0},
        '{OFS_LEVEL, 0, 0, 32'h1, 0},
        '{OFS_LINE_CFG, 1, 32'h53, 0, 0},
        '{OFS_LEVEL, 0, 0, 32'h0, 0},
        '{OFS_LEVEL_VEC, 0, 0, 32'hB, 0},
        '{12'h030, 0, 0, 32'h0, 1}
    };
    // Source code, camera levels and expected sink on line 3
    logic [3:0] src_tab[9] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hD,
                               4'h1, 4'h4};
    logic [5:0] cam_tab[9] = '{6'h2F, 6'h1F, 6'h3B, 6'h37, 6'h3D, 6'h3E,
                               6'h01, 6'h00, 6'h00};
    logic       oe_tab[9]  = '{1, 1, 1, 1, 1, 1, 0, 0, 0};

    camera_gpio_lines camera_gpio_lines_inst (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cam_in(cam_in),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .line_level(line_level)
    );
    wire_pullup_model wire_pullup_model_inst (
        .pin_oe(pin_oe), .pin_out(pin_out), .ext_low(ext_low),
        .pin_in(pin_in)
    );

    // Clock at 40 MHz
    always #12.5 mclk = ~mclk;

    // One APB transfer; only the watchdog ends a wait for pready
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Poll one line level at settled points for up to max cycles
    task automatic wait_bit(input int i, input logic v, input int max);
        ok = 1'b0;
        repeat (max) begin
            @(negedge mclk);
            if (line_level[i] === v) ok = 1'b1;
            if (ok) break;
        end
    endtask : wait_bit

    // Closing report
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // Watchdog, far beyond the fewer than a thousand cycles the tests need
    initial begin
        #(25 * 30000);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        `CHK(pin_oe, 4'h0, "pins idle after reset")
        apb(OFS_LINE_CFG, 0, 0);
        `CHK(rd_v, RESET_VALUE, "config reset value")
        $display("test reset done");
        foreach (rows[i]) begin
            apb(rows[i].addr, rows[i].wr, rows[i].data);
            if (!rows[i].wr) `CHK(rd_v, rows[i].exp, "register row")
            `CHK(er_v, rows[i].err, "error response row")
        end
        @(negedge mclk);
        `CHK(pin_oe, 4'h4, "only line 2 sinks")
        $display("test table done");
        apb(OFS_LINE_SEL, 1, 0);
        apb(OFS_FILT_SEL, 1, 0);
        apb(OFS_FILT_SPAN, 1, 32'h2);
        ext_low[0] <= 1'b1;
        repeat (20) @(posedge mclk);
        ext_low[0] <= 1'b0;
        repeat (30) @(negedge mclk);
        `CHK(line_level[0], 1'b1, "short glitch passed")
        @(posedge mclk);
        ext_low[0] <= 1'b1;
        repeat (70) @(negedge mclk);
        `CHK(line_level[0], 1'b1, "level accepted early")
        wait_bit(0, 1'b0, 90);
        `CHK(ok, 1'b1, "persisted level not accepted")
        $display("test deglitch done");
        // debounce three us on line 1
        apb(OFS_LINE_SEL, 1, 32'h1);
        apb(OFS_FILT_SEL, 1, 32'h1);
        apb(OFS_FILT_SPAN, 1, 32'h3);
        @(posedge mclk);
        ext_low[1] <= 1'b1;
        wait_bit(1, 1'b0, 12);
        `CHK(ok, 1'b1, "first edge delayed")
        @(posedge mclk);
        ext_low[1] <= 1'b0;
        repeat (60) @(negedge mclk);
        `CHK(line_level[1], 1'b0, "bounce not ignored")
        wait_bit(1, 1'b1, 140);
        `CHK(ok, 1'b1, "level lost after hold-off")
        $display("test debounce done");
        // each camera signal source, plus one line and one user source, on line 3
        apb(OFS_LINE_SEL, 1, 32'h3);
        for (int i = 0; i < 9; i++) begin
            @(posedge mclk);
            cam_in <= cam_tab[i];
            apb(OFS_LINE_CFG, 1, {24'h0, src_tab[i], 4'h1});
            repeat (4) @(negedge mclk);
            `CHK(pin_oe[3], oe_tab[i], "source select")
        end
        `CHK(pin_out, 4'h0, "drain sourced high")
        $display("test sources done");
        // invert on an input line; pin stays high
        apb(OFS_LINE_SEL, 1, 32'h1);
        apb(OFS_LINE_CFG, 1, 32'h2);
        wait_bit(1, 1'b0, 300);
        `CHK(ok, 1'b1, "input not inverted")
        $display("test invert done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
